/* File: logic/rsc_defines.svh */
`ifndef RSC_DEFINES_SVH
`define RSC_DEFINES_SVH

// Register index as printed; the byte address is four times the index.
`define RSC_REG_INDEX 12'h086
`define RSC_REG_ADDR 12'h218
`define RSC_REG_RESET 8'h81

// Field positions of the reset cause and brown-out control register.
`define RSC_BIT_POR_FLAG 7
`define RSC_BIT_EXT_FLAG 6
`define RSC_BIT_WDT_FLAG 5
`define RSC_BIT_DBG_FLAG 4
`define RSC_BIT_BOD_FLAG 3
`define RSC_BIT_LEVEL_HI 2
`define RSC_BIT_LEVEL_LO 1
`define RSC_BIT_BOD_EN 0

// Values loaded into the core on any reset.
`define RSC_INIT_PC 16'h0000
`define RSC_INIT_ACC 8'h00
`define RSC_INIT_SP 8'h07

// Timing: pclk period and the slow oscillator; times in nanoseconds, the others are counts.
`define RSC_PCLK_NS 100
`define RSC_OSC_PERIOD_NS 8000
`define RSC_OSC_DIV 32
`define RSC_PWRUP_PERIODS 48
`define RSC_NOISE_NS 7000
`define RSC_STAB_NS 16000000
`define RSC_PROC_OSC_CLOCKS 5

// Derived cycle counts; least times round up.
`define RSC_NOISE_CYCLES ((`RSC_NOISE_NS + `RSC_PCLK_NS - 1) / `RSC_PCLK_NS)
`define RSC_PWRUP_CYCLES \
    ((`RSC_PWRUP_PERIODS * `RSC_OSC_DIV * `RSC_OSC_PERIOD_NS + `RSC_PCLK_NS - 1) / `RSC_PCLK_NS)
`define RSC_STAB_CYCLES ((`RSC_STAB_NS + `RSC_PCLK_NS - 1) / `RSC_PCLK_NS)
`define RSC_PROC_CYCLES \
    ((`RSC_PROC_OSC_CLOCKS * `RSC_OSC_PERIOD_NS + `RSC_PCLK_NS - 1) / `RSC_PCLK_NS)

`endif

/* File: logic/rsc_pkg.sv */
package rsc_pkg;

    // Boot and reset sequence states.
    typedef enum logic [2:0] {
        RSC_ST_DELAY,
        RSC_ST_CFG,
        RSC_ST_HOLD,
        RSC_ST_STAB,
        RSC_ST_PROC,
        RSC_ST_RUN
    } rsc_state_e;

    // Values handed to the core while it is held in reset.
    typedef struct packed {
        logic [15:0] program_counter;
        logic [7:0] accumulator;
        logic [7:0] stack_pointer;
        logic periph_clock_on;
    } rsc_cpu_init_s;

    // Reset sources that arrive from logic on pclk.
    typedef struct packed {
        logic watchdog_overflow;
        logic watchdog_enable;
        logic debug_reset_req;
    } rsc_sources_s;

    typedef logic [17:0] rsc_count_t;

endpackage

/* File: logic/rsc_noise_filter.sv */
`timescale 1ns/10ps
`default_nettype none
`include "rsc_defines.svh"

module rsc_noise_filter
    import rsc_pkg::*;
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Raw pin and filtered result.
    input wire logic pin_n,
    output logic low_seen
);

    localparam logic [6:0] LIMIT = 7'(`RSC_NOISE_CYCLES);

    logic sync1_n;
    logic sync2_n;
    logic [6:0] low_count;

    // Two-stage synchroniser; only the second stage is read below.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_n <= 1'b1;
            sync2_n <= 1'b1;
        end else begin
            sync1_n <= pin_n;
            sync2_n <= sync1_n;
        end
    end

    // A low must last the full window before it counts; a high ends it at once.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_count <= 7'h00;
            low_seen <= 1'b0;
        end else if (sync2_n) begin
            low_count <= 7'h00;
            low_seen <= 1'b0;
        end else if (low_count != LIMIT) begin
            low_count <= low_count + 7'h01;
        end else begin
            low_seen <= 1'b1; // [RULE_05]
        end
    end

endmodule
`default_nettype wire

/* File: logic/rsc_cycle_timer.sv */
`timescale 1ns/10ps
`default_nettype none

module rsc_cycle_timer
    import rsc_pkg::*;
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Start with a count, pulse when it has run out.
    input wire logic load,
    input wire rsc_count_t load_value,
    output logic done
);

    rsc_count_t count;
    logic armed;

    // Done is a one-cycle pulse that fires load_value cycles after the load.
    assign done = armed && (count == 18'h00000);

    // A load restarts the count even while a previous one is running.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 18'h00000;
            armed <= 1'b0;
        end else if (load) begin
            count <= load_value - 18'h00001;
            armed <= 1'b1;
        end else if (done) begin
            armed <= 1'b0;
        end else if (count != 18'h00000) begin
            count <= count - 18'h00001;
        end
    end

endmodule
`default_nettype wire

/* File: logic/rsc_reset_source_controller.sv */
// Decided for this implementation: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "rsc_defines.svh"

// Overview of operation
// RULE_01 - Any reset loads PC 0, accumulator 0, SP 7, clock on, detector on.
// RULE_02 - Five reset sources: pin, power-on, watchdog, brown-out, debug.
// RULE_03 - Watchdog overflow resets only while watchdog enable is one.
// RULE_04 - Brown-out resets only while the detector enable bit is one.
// RULE_05 - Pin lows shorter than about 7 us are ignored as noise.
// RULE_06 - Outside party holds the pin low at least 7 us to reset.
// RULE_07 - Power-on resets the device; pin may then serve as plain I/O.
// RULE_08 - After power-on wait 0x30 periods of 125 kHz/32 before config read.
// RULE_09 - At delay end the programmed option values are read in.
// RULE_10 - Internal reset releases on interval timer overflow, 16 ms later.
// RULE_11 - After the pin returns high wait 16 ms before releasing reset.
// RULE_12 - Reset processing lasts five oscillator clocks.
// RULE_13 - Execution starts at the vector held at address zero.
// RULE_14 - Two-bit field selects brown-out level 1.6, 2.5, 3.6 or 4.2 V.
// RULE_15 - Software can clear the detector enable bit to turn it off.
// RULE_16 - Control register sits at index 0x86, read-write, default 0x81.
// RULE_17 - Bits: 7 por, 6 ext, 5 wdt, 4 dbg, 3 bod flag, 2:1 level, 0 enable.
// RULE_18 - Power-on flag reads one after power-on; writing zero clears it.
// RULE_19 - Pin flag set by pin reset, cleared by writing zero or power-on.
// RULE_20 - Watchdog, debug, brown-out flags likewise set and cleared.
// RULE_21 - A flag set in the same cycle as its clear wins over the clear.
module rsc_reset_source_controller
    import rsc_pkg::*;
#(
    parameter rsc_count_t POWERUP_CYCLES = 18'(`RSC_PWRUP_CYCLES),
    parameter rsc_count_t STAB_CYCLES = 18'(`RSC_STAB_CYCLES)
)
(
    // Clock and power-on reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Reset sources.
    input wire logic ext_reset_pin_n,
    input wire logic ext_reset_pin_enable,
    input wire logic brownout_detected,
    input wire rsc_sources_s sources,
    // Configuration options read during boot.
    input wire logic [7:0] cfg_option,
    output logic [7:0] cfg_value,
    output logic cfg_valid,
    // Brown-out detector control.
    output logic brownout_enable,
    output logic [1:0] brownout_level_select,
    // Core reset and initial values.
    output logic sys_reset_n,
    output rsc_cpu_init_s cpu_init,
    output logic [15:0] reset_vector_addr
);

    localparam rsc_count_t PROC_CYCLES = 18'(`RSC_PROC_CYCLES);

    // Next value of one cause flag: a set beats a software clear.
    function automatic logic flag_next(input logic cur, input logic wr_en,
                                       input logic wr_bit, input logic set);
        flag_next = set | (cur & ~(wr_en & ~wr_bit));
    endfunction

    rsc_state_e state;
    rsc_state_e next_state;
    logic [7:0] ctrl;
    logic [7:0] next_ctrl;
    logic started;
    logic bod_sync1;
    logic bod_sync2;
    logic ext_low;
    logic timer_done;
    logic timer_load;
    rsc_count_t timer_value;

    // Pin noise filter with its own synchroniser.
    rsc_noise_filter u_filter (
        .pclk(pclk),
        .presetn(presetn),
        .pin_n(ext_reset_pin_n),
        .low_seen(ext_low)
    );

    // One shared down-counter times the power-up delay, settle and processing phases.
    rsc_cycle_timer u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .load(timer_load),
        .load_value(timer_value),
        .done(timer_done)
    );

    // The comparator output is asynchronous, so it is synchronised first.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bod_sync1 <= 1'b0;
            bod_sync2 <= 1'b0;
        end else begin
            bod_sync1 <= brownout_detected;
            bod_sync2 <= bod_sync1;
        end
    end

    // Reset sources; all but the debug request are gated by an enable.
    wire pin_reset = ext_low & ext_reset_pin_enable; // [RULE_02] [RULE_07]
    wire wdt_reset = sources.watchdog_overflow & sources.watchdog_enable; // [RULE_03]
    wire bod_reset = bod_sync2 & ctrl[`RSC_BIT_BOD_EN]; // [RULE_04]
    wire dbg_reset = sources.debug_reset_req; // [RULE_02]
    wire hold_level = pin_reset | bod_reset;
    wire any_reset = hold_level | wdt_reset | dbg_reset;

    // APB decode; the slave never inserts wait states.
    wire addr_hit = (paddr == `RSC_REG_ADDR); // [RULE_16]
    wire access = psel & penable;
    wire wr_en = access & pwrite & addr_hit & pstrb[0];
    wire [7:0] wd = pwdata[7:0];
    assign pready = 1'b1;
    assign pslverr = access & ~addr_hit;
    assign prdata = (psel & addr_hit & ~pwrite) ? {24'h000000, ctrl} : 32'h00000000;

    // Flags, level select and enable; any reset turns the detector back on.
    always_comb begin
        next_ctrl = ctrl;
        next_ctrl[`RSC_BIT_POR_FLAG] =
            flag_next(ctrl[`RSC_BIT_POR_FLAG], wr_en, wd[`RSC_BIT_POR_FLAG], 1'b0); // [RULE_18]
        next_ctrl[`RSC_BIT_EXT_FLAG] =
            flag_next(ctrl[`RSC_BIT_EXT_FLAG], wr_en, wd[`RSC_BIT_EXT_FLAG], pin_reset); // [RULE_19] [RULE_21]
        next_ctrl[`RSC_BIT_WDT_FLAG] =
            flag_next(ctrl[`RSC_BIT_WDT_FLAG], wr_en, wd[`RSC_BIT_WDT_FLAG], wdt_reset); // [RULE_20] [RULE_21]
        next_ctrl[`RSC_BIT_DBG_FLAG] =
            flag_next(ctrl[`RSC_BIT_DBG_FLAG], wr_en, wd[`RSC_BIT_DBG_FLAG], dbg_reset); // [RULE_20] [RULE_21]
        next_ctrl[`RSC_BIT_BOD_FLAG] =
            flag_next(ctrl[`RSC_BIT_BOD_FLAG], wr_en, wd[`RSC_BIT_BOD_FLAG], bod_reset); // [RULE_20] [RULE_21]
        if (wr_en) begin
            next_ctrl[`RSC_BIT_LEVEL_HI:`RSC_BIT_LEVEL_LO] =
                wd[`RSC_BIT_LEVEL_HI:`RSC_BIT_LEVEL_LO]; // [RULE_14] [RULE_17]
            next_ctrl[`RSC_BIT_BOD_EN] = wd[`RSC_BIT_BOD_EN]; // [RULE_15]
        end
        if (any_reset) begin
            next_ctrl[`RSC_BIT_BOD_EN] = 1'b1; // [RULE_01]
        end
    end

    // Power-on leaves only the power-on flag and the enable set.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `RSC_REG_RESET; // [RULE_16] [RULE_18] [RULE_19] [RULE_20]
        end else begin
            ctrl <= next_ctrl;
        end
    end

    assign brownout_enable = ctrl[`RSC_BIT_BOD_EN];
    assign brownout_level_select = ctrl[`RSC_BIT_LEVEL_HI:`RSC_BIT_LEVEL_LO]; // [RULE_14]

    // Sequence: power-up delay, option read, hold, 16 ms settle, processing, run.
    always_comb begin
        next_state = state;
        case (state)
            RSC_ST_DELAY: begin
                if (timer_done) begin
                    next_state = RSC_ST_CFG; // [RULE_08]
                end
            end
            RSC_ST_CFG: begin
                next_state = any_reset ? RSC_ST_HOLD : RSC_ST_STAB; // [RULE_09]
            end
            RSC_ST_HOLD: begin
                if (!any_reset) begin
                    next_state = RSC_ST_STAB; // [RULE_11]
                end
            end
            RSC_ST_STAB: begin
                if (any_reset) begin
                    next_state = RSC_ST_HOLD;
                end else if (timer_done) begin
                    next_state = RSC_ST_PROC; // [RULE_10]
                end
            end
            RSC_ST_PROC: begin
                if (any_reset) begin
                    next_state = RSC_ST_HOLD;
                end else if (timer_done) begin
                    next_state = RSC_ST_RUN; // [RULE_12]
                end
            end
            RSC_ST_RUN: begin
                if (any_reset) begin
                    next_state = RSC_ST_HOLD;
                end
            end
            default: begin
                next_state = RSC_ST_HOLD;
            end
        endcase
    end

    // The timer is loaded on entry to each timed phase.
    wire entering = (next_state != state);
    assign timer_load = ~started | (entering & ((next_state == RSC_ST_STAB) |
                        (next_state == RSC_ST_PROC)));
    assign timer_value = ~started ? POWERUP_CYCLES : // [RULE_08]
                         (next_state == RSC_ST_PROC) ? PROC_CYCLES : // [RULE_12]
                         STAB_CYCLES; // [RULE_10] [RULE_11]

    // State register and the first-cycle marker that starts the power-up delay.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= RSC_ST_DELAY;
            started <= 1'b0;
        end else begin
            state <= next_state;
            started <= 1'b1;
        end
    end

    // Options are latched once per power-on, in the single read cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_value <= 8'h00;
            cfg_valid <= 1'b0;
        end else if (state == RSC_ST_CFG) begin
            cfg_value <= cfg_option; // [RULE_09]
            cfg_valid <= 1'b1;
        end
    end

    // The core sees its start values for as long as it is held in reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_reset_n <= 1'b0;
            cpu_init <= '{`RSC_INIT_PC, `RSC_INIT_ACC, `RSC_INIT_SP, 1'b1};
            reset_vector_addr <= `RSC_INIT_PC;
        end else begin
            sys_reset_n <= (next_state == RSC_ST_RUN); // [RULE_10]
            if (next_state != RSC_ST_RUN) begin
                cpu_init <= '{`RSC_INIT_PC, `RSC_INIT_ACC, `RSC_INIT_SP, 1'b1}; // [RULE_01]
                reset_vector_addr <= `RSC_INIT_PC; // [RULE_13]
            end
        end
    end

endmodule
`default_nettype wire

/* File: testbench/rsc_reset_source_controller_props.sv */
`timescale 1ns/10ps
`default_nettype none
`include "rsc_defines.svh"
module rsc_reset_source_controller_props
    import rsc_pkg::*;
#(
    parameter rsc_count_t POWERUP_CYCLES = 18'h14,
    parameter rsc_count_t STAB_CYCLES = 18'h1e
)
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Register bus.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Sources and outputs watched.
    input wire rsc_sources_s sources,
    input wire logic cfg_valid,
    input wire logic brownout_enable,
    input wire logic [1:0] brownout_level_select,
    input wire logic sys_reset_n,
    input wire rsc_cpu_init_s cpu_init,
    input wire logic [15:0] reset_vector_addr
);
    // Access phase aimed at the one mapped register.
    wire logic hit = psel && penable && (paddr == `RSC_REG_ADDR);

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // The slave never inserts wait states.
    zero_wait_a: assert property (pready)
        else $error("pready low");
    miss_err_a: assert property (psel && penable && !hit |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    level_write_a: assert property (hit && pwrite && pstrb[0] |=>
        brownout_level_select == $past(pwdata[2:1])) else $error("level not stored");
    field_read_a: assert property (hit && !pwrite |-> prdata[31:8] == 24'h0 &&
        prdata[2:0] == {brownout_level_select, brownout_enable}) else $error("bad field read");
    init_vals_a: assert property (!sys_reset_n |->
        cpu_init == {16'h0000, 8'h00, 8'h07, 1'h1}) else $error("bad core init");
    vector_zero_a: assert property (reset_vector_addr == 16'h0000)
        else $error("vector not zero");
    debug_reset_a: assert property (sys_reset_n && sources.debug_reset_req |->
        ##[1:3] !sys_reset_n) else $error("debug request ignored");
    wdt_reset_a: assert property (sys_reset_n && sources.watchdog_overflow &&
        sources.watchdog_enable |-> ##[1:3] !sys_reset_n) else $error("overflow ignored");
    cfg_first_a: assert property ($rose(sys_reset_n) |-> cfg_valid)
        else $error("release before config read");
    proc_hold_a: assert property ($rose(sys_reset_n) |-> !$past(sys_reset_n, 300))
        else $error("release too early");
endmodule

bind rsc_reset_source_controller rsc_reset_source_controller_props #(
    .POWERUP_CYCLES(POWERUP_CYCLES), .STAB_CYCLES(STAB_CYCLES)) i_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sources(sources), .cfg_valid(cfg_valid),
    .brownout_enable(brownout_enable), .brownout_level_select(brownout_level_select),
    .sys_reset_n(sys_reset_n), .cpu_init(cpu_init), .reset_vector_addr(reset_vector_addr));
`default_nettype wire

/* File: testbench/rsc_source_model.sv */
`timescale 1ns/10ps
`default_nettype none
module rsc_source_model (
    // Clock.
    input wire logic pclk,
    // Request for a low pulse of the given length.
    input wire logic go,
    input wire logic [7:0] low_len,
    // Reset pin; the board pull-up holds it high when idle.
    output logic pin_n
);
    logic [7:0] left = 8'h00;
    // Count the low time down; the pin is only driven low while counting.
    always @(posedge pclk) begin
        if (go) begin
            left <= low_len;
        end else if (left != 8'h00) begin
            left <= left - 8'h01;
        end
    end
    assign pin_n = (left == 8'h00);
endmodule
`default_nettype wire

/* File: testbench/rsc_reset_source_controller_test.sv */
`timescale 1ns/10ps
`default_nettype none
`include "rsc_defines.svh"
module rsc_reset_source_controller_test;
    import rsc_pkg::*;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, pin_n, cfg_valid, bo_en, sys_reset_n, err;
    logic go = 1'h0;
    logic bo_hit = 1'h0;
    logic pin_en = 1'h1;
    logic [7:0] low_len = 8'h00;
    logic [7:0] cfg_value;
    logic [1:0] bo_lvl;
    logic [15:0] vec;
    logic [31:0] rd;
    rsc_sources_s src = '0;
    rsc_cpu_init_s cpu_init;
    int num_errors = 0;
    int compares = 0;
    int n;

    // Free-running bus clock.
    always #50 pclk = ~pclk;

    rsc_reset_source_controller #(.POWERUP_CYCLES(18'h14), .STAB_CYCLES(18'h1e))
        i_rsc_reset_source_controller (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_reset_pin_n(pin_n), .ext_reset_pin_enable(pin_en),
        .brownout_detected(bo_hit), .sources(src), .cfg_option(8'h5a),
        .cfg_value(cfg_value), .cfg_valid(cfg_valid), .brownout_enable(bo_en),
        .brownout_level_select(bo_lvl), .sys_reset_n(sys_reset_n), .cpu_init(cpu_init),
        .reset_vector_addr(vec));

    rsc_source_model i_rsc_source_model (.pclk(pclk), .go(go), .low_len(low_len),
        .pin_n(pin_n));

    task automatic close_out;
        if (num_errors == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; the request stands until pready is seen high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic reg_chk(input logic [31:0] exp);
        apb(1'h0, `RSC_REG_ADDR, 32'h0);
        chk(rd, exp);
    endtask

    // Counts cycles until the core is let go; the watchdog bounds it.
    task automatic wait_run;
        n = 0;
        while (sys_reset_n !== 1'h1) begin
            @(posedge pclk);
            n++;
        end
    endtask

    task automatic t_regs;
        apb(1'h0, 12'h000, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        apb(1'h1, 12'h004, 32'hff);
        reg_chk(32'h81);
        for (int l = 0; l < 4; l++) begin
            apb(1'h1, `RSC_REG_ADDR, {24'h0, 5'h00, 2'(l), 1'h1});
            reg_chk({24'h0, 5'h00, 2'(l), 1'h1});
            chk({30'h0, bo_lvl}, 32'(l));
        end
        apb(1'h1, `RSC_REG_ADDR, 32'h0);
        reg_chk(32'h0);
        chk({31'h0, bo_en}, 32'h0);
    endtask

    // Gated sources must be ignored while their enable is off.
    task automatic t_gates;
        bo_hit <= 1'h1;
        src.watchdog_overflow <= 1'h1;
        repeat (6) @(posedge pclk);
        bo_hit <= 1'h0;
        src.watchdog_overflow <= 1'h0;
        chk({31'h0, sys_reset_n}, 32'h1);
        reg_chk(32'h0);
        src <= '{1'h1, 1'h1, 1'h0};
        @(posedge pclk);
        src <= '0;
        repeat (3) @(posedge pclk);
        chk({31'h0, sys_reset_n}, 32'h0);
        reg_chk(32'h21);
        wait_run();
        // With the detector enabled a brown-out must reset and leave its flag.
        apb(1'h1, `RSC_REG_ADDR, 32'h1);
        bo_hit <= 1'h1;
        repeat (4) @(posedge pclk);
        bo_hit <= 1'h0;
        chk({31'h0, sys_reset_n}, 32'h0);
        reg_chk(32'h09);
        wait_run();
        apb(1'h1, `RSC_REG_ADDR, 32'h0);
    endtask

    task automatic pulse(input logic [7:0] len);
        low_len <= len;
        go <= 1'h1;
        @(posedge pclk);
        go <= 1'h0;
        repeat (len) @(posedge pclk);
    endtask

    // A short low is noise; a long one resets and starts the settle wait, shortened here to 30 cycles.
    task automatic t_pin;
        pulse(8'h3c);
        repeat (20) @(posedge pclk);
        chk({31'h0, sys_reset_n}, 32'h1);
        reg_chk(32'h0);
        // While the pin serves as plain I/O even a long low must not reset.
        pin_en <= 1'h0;
        pulse(8'h64);
        chk({31'h0, sys_reset_n}, 32'h1);
        reg_chk(32'h0);
        repeat (5) @(posedge pclk);
        pin_en <= 1'h1;
        pulse(8'h64);
        chk({31'h0, sys_reset_n}, 32'h0);
        reg_chk(32'h41);
        wait_run();
        chk(32'(n >= 420 && n <= 440), 32'h1);
        apb(1'h1, `RSC_REG_ADDR, 32'h0);
    endtask

    // A flag set while software clears it must survive the clear.
    task automatic t_debug;
        src.debug_reset_req <= 1'h1;
        repeat (4) @(posedge pclk);
        chk({31'h0, sys_reset_n}, 32'h0);
        apb(1'h1, `RSC_REG_ADDR, 32'h0);
        reg_chk(32'h11);
        src.debug_reset_req <= 1'h0;
        wait_run();
    endtask

    task automatic t_boot;
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        wait_run();
        chk(32'(n >= 449 && n <= 456), 32'h1);
        chk({23'h0, cfg_valid, cfg_value}, 32'h15a);
        chk(cpu_init[32:1], 32'h00000007);
        chk({31'h0, cpu_init.periph_clock_on}, 32'h1);
        chk({16'h0, vec}, 32'h0);
        reg_chk(32'h81);
    endtask

    // Main sequence; the second boot also shows that power-on clears the flags.
    initial begin
        t_boot();
        t_regs();
        t_gates();
        t_pin();
        t_debug();
        t_boot();
        close_out();
    end

    // Whole run needs about 3000 cycles; give it a wide margin.
    initial begin
        #1000000;
        num_errors++;
        close_out();
    end
endmodule
`default_nettype wire
